// *** hdl/eis_core.sv ***
// selection core of the eight input selector
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - valid means enabled and good or allowed uncertain
// - forced input one to eight drives auto result unless no input valid or count below minimum
// - equal values prefer the lower input number
// - first good takes lowest valid input
// - minimum takes smallest valid value and index
// - maximum takes largest valid value and index
// - odd middle gives median value and index
// - even middle gives mean of centre pair
// - two value middle average reports index zero
// - average outputs mean, index is valid count
// - latched good holds lowest valid input choice
// - invalid latch moves upward, wraps eight to one
// - latched choice ignores lower input recovery
// - latched choice survives power cycle via restore
// - forced number copied to index when no error
// - index zero when no input valid
// - index zero when minimum count exceeds valid count
// - forced input of poor quality zeroes index
// - forced number above eight zeroes index
// - bad algorithm code with no force zeroes index
// - single valid input reports its number, average one
// - index zero outside automatic mode
module eis_core (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic exec_i,
	input wire eis_pkg::eis_input_type [7:0] chan_i,
	input wire logic [7:0] disable_i,
	input wire eis_pkg::eis_config_type status_handling_options_i,
	input wire logic [15:0] man_value_i,
	input wire logic [3:0] latch_restore_i,
	input wire logic latch_restore_load_i,
	output logic [15:0] result_o,
	output logic [3:0] selected_o,
	output logic [3:0] latched_choice_o,
	output logic [3:0] valid_count_o
);
	eis_pkg::eis_config_type cfg;
	logic [7:0] valid;
	logic [3:0] count;
	logic [3:0] forced;
	logic forced_over;
	logic forced_poor;
	logic type_ok;
	logic no_valid;
	logic short_good;
	logic [3:0] rank_lo [8];
	logic [3:0] rank_hi [8];
	logic [3:0] first_idx;
	logic [3:0] min_idx;
	logic [3:0] max_idx;
	logic [3:0] mid_a_idx;
	logic [3:0] mid_b_idx;
	logic [3:0] lat_scan_idx;
	logic signed [18:0] sum;
	logic signed [16:0] mid_pair;
	logic signed [18:0] avg_full;
	logic [3:0] mid_lo;
	logic [3:0] mid_hi;
	logic lat_keep;
	logic [15:0] algo_value;
	logic [3:0] algo_index;
	logic [15:0] next_result;
	logic [3:0] next_selected;
	logic [3:0] next_latched;

	assign cfg = status_handling_options_i;
	assign forced = cfg.operator_forced_input;

	function automatic logic qual_ok(input logic [1:0] q, input logic unc);
		qual_ok = (q == eis_pkg::QUAL_GOOD_NC) ||
			(q == eis_pkg::QUAL_GOOD_C) ||
			((q == eis_pkg::QUAL_UNCERTAIN) && unc);
	endfunction

	// index is one based; zero wraps to a harmless read of input eight
	function automatic logic signed [15:0] val_of(
		input eis_pkg::eis_input_type [7:0] ch, input logic [3:0] idx);
		logic [2:0] k;
		k = 3'(idx - 4'h1);
		val_of = ch[k].value;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_valid
			assign valid[g] = !disable_i[g] &&
				qual_ok(chan_i[g].quality, cfg.uncertain_as_good);
		end
	endgenerate

	assign count = 4'($countones(valid));
	assign no_valid = (count == 4'h0);
	assign short_good = (cfg.min_good > count);
	assign forced_over = (forced > eis_pkg::IDX_MAX);
	assign forced_poor = (forced != 4'h0) && !forced_over &&
		!qual_ok(chan_i[3'(forced - 4'h1)].quality,
		cfg.uncertain_as_good);
	assign type_ok = (cfg.select_type >= eis_pkg::SEL_FIRST_GOOD) &&
		(cfg.select_type <= eis_pkg::SEL_LATCHED_GOOD);
	assign mid_lo = 4'((count - 4'h1) >> 1);
	assign mid_hi = 4'(count >> 1);

	// ranks break ties by input number so every valid input is unique
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			rank_lo[i] = 4'h0;
			rank_hi[i] = 4'h0;
			for (int j = 0; j < 8; j++) begin
				if (valid[j] && (j != i)) begin
					if ((chan_i[j].value < chan_i[i].value) ||
						((chan_i[j].value == chan_i[i].value) &&
						(j < i))) begin
						rank_lo[i] = rank_lo[i] + 4'h1;
					end
					if ((chan_i[j].value > chan_i[i].value) ||
						((chan_i[j].value == chan_i[i].value) &&
						(j < i))) begin
						rank_hi[i] = rank_hi[i] + 4'h1;
					end
				end
			end
		end
	end

	always_comb begin
		first_idx = 4'h0;
		min_idx = 4'h0;
		max_idx = 4'h0;
		mid_a_idx = 4'h0;
		mid_b_idx = 4'h0;
		sum = 19'sh0;
		for (int i = 7; i >= 0; i--) begin
			if (valid[i]) begin
				first_idx = 4'(i + 1);
				sum = sum + 19'(chan_i[i].value);
				if (rank_lo[i] == 4'h0) begin
					min_idx = 4'(i + 1);
				end
				if (rank_hi[i] == 4'h0) begin
					max_idx = 4'(i + 1);
				end
				if (rank_lo[i] == mid_lo) begin
					mid_a_idx = 4'(i + 1);
				end
				if (rank_lo[i] == mid_hi) begin
					mid_b_idx = 4'(i + 1);
				end
			end
		end
	end

	// scan upward from the latched input, wrapping eight to one
	always_comb begin
		lat_scan_idx = 4'h0;
		for (int k = 8; k >= 1; k--) begin
			if (valid[3'(latched_choice_o + 4'(k) - 4'h1)]) begin
				lat_scan_idx = 4'(((latched_choice_o + 4'(k) - 4'h1)
					& 4'h7) + 4'h1);
			end
		end
	end

	// a latched input that stays valid is kept, even over lower ones
	assign lat_keep = (latched_choice_o != 4'h0) &&
		(latched_choice_o <= eis_pkg::IDX_MAX) &&
		valid[3'(latched_choice_o - 4'h1)];
	assign next_latched = lat_keep ? latched_choice_o : lat_scan_idx;

	assign mid_pair = (17'(val_of(chan_i, mid_a_idx)) +
		17'(val_of(chan_i, mid_b_idx))) >>> 1;
	// divide by a small count; fits easily in a 100 ns cycle
	assign avg_full = no_valid ? 19'sh0 :
		sum / $signed({15'h0, count});

	always_comb begin
		algo_value = result_o;
		algo_index = 4'h0;
		case (cfg.select_type)
			eis_pkg::SEL_FIRST_GOOD: begin
				algo_value = val_of(chan_i, first_idx);
				algo_index = first_idx;
			end
			eis_pkg::SEL_MINIMUM: begin
				algo_value = val_of(chan_i, min_idx);
				algo_index = min_idx;
			end
			eis_pkg::SEL_MAXIMUM: begin
				algo_value = val_of(chan_i, max_idx);
				algo_index = max_idx;
			end
			eis_pkg::SEL_MIDDLE: begin
				if (count[0]) begin
					algo_value = val_of(chan_i, mid_a_idx);
					algo_index = mid_a_idx;
				end else begin
					algo_value = 16'(mid_pair);
					algo_index = 4'h0;
				end
			end
			eis_pkg::SEL_AVERAGE: begin
				algo_value = 16'(avg_full);
				algo_index = count;
			end
			eis_pkg::SEL_LATCHED_GOOD: begin
				algo_value = val_of(chan_i, next_latched);
				algo_index = next_latched;
			end
			default: begin
				algo_value = result_o;
				algo_index = 4'h0;
			end
		endcase
	end

	always_comb begin
		next_result = result_o;
		next_selected = 4'h0;
		case (cfg.block_mode_setting)
			eis_pkg::MODE_MAN: begin
				next_result = man_value_i;
			end
			eis_pkg::MODE_AUTO: begin
				if (forced_over) begin
					next_result = eis_pkg::RESULT_RESET;
				end else if (no_valid || short_good) begin
					next_result = result_o;
				end else if (forced != 4'h0) begin
					next_result = val_of(chan_i, forced);
					next_selected = forced_poor ? 4'h0 : forced;
				end else if (!type_ok) begin
					next_result = result_o;
				end else begin
					next_result = algo_value;
					next_selected = algo_index;
				end
			end
			default: begin
				next_result = result_o;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			result_o <= eis_pkg::RESULT_RESET;
			selected_o <= eis_pkg::IDX_NONE;
			valid_count_o <= eis_pkg::IDX_NONE;
		end else if (exec_i) begin
			result_o <= next_result;
			selected_o <= next_selected;
			valid_count_o <= count;
		end
	end

	// latch is reloaded from nonvolatile storage after power up
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			latched_choice_o <= eis_pkg::IDX_NONE;
		end else if (latch_restore_load_i) begin
			latched_choice_o <= latch_restore_i;
		end else if (exec_i && !no_valid &&
			(cfg.select_type == eis_pkg::SEL_LATCHED_GOOD)) begin
			latched_choice_o <= next_latched;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	wire auto_run = exec_i && (cfg.block_mode_setting == eis_pkg::MODE_AUTO);
	wire auto_clean = auto_run && !forced_over && !no_valid && !short_good;

	sequence s_idle_step;
		!exec_i && !latch_restore_load_i;
	endsequence

	a_mode_index_zero: assert property (exec_i &&
		(cfg.block_mode_setting != eis_pkg::MODE_AUTO) |=>
		selected_o == 4'h0) else $error("index not zero outside auto");
	a_no_valid_zero: assert property (exec_i && no_valid |=>
		selected_o == 4'h0) else $error("index not zero with no valid");
	a_short_good_zero: assert property (exec_i && short_good |=>
		selected_o == 4'h0) else $error("index not zero below min");
	a_forced_over_zero: assert property (auto_run && forced_over |=>
		(selected_o == 4'h0) && (result_o == 16'h0000))
		else $error("forced above eight not zeroed");
	a_forced_copy: assert property (auto_clean &&
		(forced != 4'h0) && !forced_poor |=> (selected_o == $past(forced)) &&
		(result_o == $past(val_of(chan_i, forced))))
		else $error("forced input not passed");
	a_forced_poor_zero: assert property (auto_clean &&
		forced_poor |=> selected_o == 4'h0)
		else $error("poor forced input not zeroed");
	// lowest set bit of the valid mask names the first good input
	a_first_good_idx: assert property (auto_clean &&
		(forced == 4'h0) && (cfg.select_type == eis_pkg::SEL_FIRST_GOOD)
		|=> (8'h1 << (selected_o - 4'h1)) ==
		($past(valid) & (~$past(valid) + 8'h1)))
		else $error("first good index wrong");
	a_average_count: assert property (auto_clean &&
		(forced == 4'h0) && (cfg.select_type == eis_pkg::SEL_AVERAGE) |=>
		selected_o == $past(count)) else $error("average index wrong");
	a_even_mid_zero: assert property (auto_clean &&
		(forced == 4'h0) && (cfg.select_type == eis_pkg::SEL_MIDDLE) &&
		!count[0] |=> selected_o == 4'h0)
		else $error("even middle index not zero");
	a_bad_type_zero: assert property (auto_clean &&
		(forced == 4'h0) && !type_ok |=>
		(selected_o == 4'h0) && $stable(result_o))
		else $error("bad algorithm code not handled");
	a_latch_persist: assert property (exec_i && lat_keep &&
		!latch_restore_load_i |=> $stable(latched_choice_o))
		else $error("latched choice moved while valid");
	a_hold_between: assert property (s_idle_step ##1 s_idle_step |->
		$stable(result_o) && $stable(selected_o) &&
		$stable(latched_choice_o)) else $error("changed without strobe");
	a_manual_value: assert property (exec_i &&
		(cfg.block_mode_setting == eis_pkg::MODE_MAN) |=>
		result_o == $past(man_value_i))
		else $error("manual value not loaded");
	a_stopped_hold: assert property (exec_i &&
		(cfg.block_mode_setting != eis_pkg::MODE_AUTO) &&
		(cfg.block_mode_setting != eis_pkg::MODE_MAN) |=>
		$stable(result_o)) else $error("result moved out of service");
	a_short_hold: assert property (auto_run && !forced_over &&
		(no_valid || short_good) |=> $stable(result_o))
		else $error("result moved without selection");
	a_restore_load: assert property (latch_restore_load_i |=>
		latched_choice_o == $past(latch_restore_i))
		else $error("latched choice not restored");
	a_single_average: assert property (auto_clean &&
		(forced == 4'h0) && (cfg.select_type == eis_pkg::SEL_AVERAGE) &&
		(count == 4'h1) |=> selected_o == 4'h1)
		else $error("single average index not one");
	a_index_range: assert property (auto_run |=>
		selected_o <= eis_pkg::IDX_MAX) else $error("index above eight");
	a_latch_lowest: assert property (exec_i &&
		(cfg.select_type == eis_pkg::SEL_LATCHED_GOOD) &&
		(latched_choice_o == 4'h0) && !no_valid && !latch_restore_load_i
		|=> (8'h1 << (latched_choice_o - 4'h1)) ==
		($past(valid) & (~$past(valid) + 8'h1)))
		else $error("latch did not take lowest valid");
endmodule
`default_nettype wire

// *** include/eis_pkg.sv ***
// constants and types shared by the eight input selector core
`default_nettype none
package eis_pkg;
	localparam int unsigned NUM_INPUTS = 8;
	localparam int unsigned VAL_W = 16;
	localparam int unsigned IDX_W = 4;
	localparam int unsigned SUM_W = VAL_W + 3;

	// quality codes carried with each input value
	localparam logic [1:0] QUAL_BAD = 2'h0;
	localparam logic [1:0] QUAL_UNCERTAIN = 2'h1;
	localparam logic [1:0] QUAL_GOOD_NC = 2'h2;
	localparam logic [1:0] QUAL_GOOD_C = 2'h3;

	// selection algorithm codes; anything else is out of range
	localparam logic [2:0] SEL_FIRST_GOOD = 3'h1;
	localparam logic [2:0] SEL_MINIMUM = 3'h2;
	localparam logic [2:0] SEL_MAXIMUM = 3'h3;
	localparam logic [2:0] SEL_MIDDLE = 3'h4;
	localparam logic [2:0] SEL_AVERAGE = 3'h5;
	localparam logic [2:0] SEL_LATCHED_GOOD = 3'h6;

	// block mode setting codes
	localparam logic [1:0] MODE_OOS = 2'h0;
	localparam logic [1:0] MODE_MAN = 2'h1;
	localparam logic [1:0] MODE_AUTO = 2'h2;

	localparam logic [IDX_W-1:0] IDX_NONE = 4'h0;
	localparam logic [IDX_W-1:0] IDX_MAX = 4'h8;
	localparam logic [VAL_W-1:0] RESULT_RESET = 16'h0000;

	typedef struct packed {
		logic [1:0] quality;
		logic signed [VAL_W-1:0] value;
	} eis_input_type;

	typedef struct packed {
		logic uncertain_as_good;
		logic [IDX_W-1:0] min_good;
		logic [2:0] select_type;
		logic [1:0] block_mode_setting;
		logic [IDX_W-1:0] operator_forced_input;
	} eis_config_type;
endpackage
`default_nettype wire

// *** bench/eis_src_model.sv ***
// upstream analog input sources feeding the selector core
`timescale 1ns/100ps
`default_nettype none
module eis_src_model (
	input wire logic [7:0][15:0] val_i,
	input wire logic [7:0][1:0] qual_i,
	output var eis_pkg::eis_input_type [7:0] chan_o
);
	// each source publishes a value and its quality together, as a pair
	genvar g;
	for (g = 0; g < 8; g++) begin : g_src
		assign chan_o[g].quality = qual_i[g];
		assign chan_o[g].value = val_i[g];
	end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the eight input selector core
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
	logic ref_clk_i;
	logic rst_b_i;
	logic exec;
	logic [7:0] dis;
	logic [7:0][15:0] val;
	logic [7:0][1:0] qual;
	logic [15:0] man_value;
	logic [3:0] restore;
	logic restore_load;
	eis_pkg::eis_config_type cfg;
	eis_pkg::eis_input_type [7:0] chan;
	logic [15:0] result;
	logic [3:0] selected;
	logic [3:0] latched;
	logic [3:0] vcount;
	int fail_count = 0;
	int checked = 0;
	eis_src_model src (.val_i(val), .qual_i(qual), .chan_o(chan));
	eis_core DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .exec_i(exec),
		.chan_i(chan), .disable_i(dis), .status_handling_options_i(cfg),
		.man_value_i(man_value), .latch_restore_i(restore),
		.latch_restore_load_i(restore_load), .result_o(result),
		.selected_o(selected), .latched_choice_o(latched),
		.valid_count_o(vcount));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	task automatic complete_run;
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// one strobe, compare once the edge has landed, then one idle edge
	// so the strobe never falls and rises in the same time step
	task automatic go(input logic [2:0] t, input logic [7:0] d,
		input logic [3:0] f, input logic [3:0] es, input logic [15:0] er);
		cfg.select_type = t;
		cfg.operator_forced_input = f;
		dis = d;
		exec = 1'b1;
		@(posedge ref_clk_i);
		#10;
		exec = 1'b0;
		`CHK("selected", es, selected)
		`CHK("result", er, result)
		@(posedge ref_clk_i);
		#10;
	endtask
	initial begin
		exec = 1'b0;
		dis = 8'h00;
		val = {16'h001b, 16'h0020, 16'h000f, 16'h0018, 16'h0002, 16'h002d,
			16'h0022, 16'h0017};
		qual = {8{2'h2}};
		man_value = 16'h1234;
		restore = 4'h0;
		restore_load = 1'b0;
		cfg = '{uncertain_as_good: 1'b0, min_good: 4'h0, select_type: 3'h1,
			block_mode_setting: 2'h2, operator_forced_input: 4'h0};
		rst_b_i = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		#10;
		rst_b_i = 1'b1;
		`CHK("selected", 4'h0, selected)
		go(3'h1, 8'h01, 4'h0, 4'h2, 16'h0022);
		go(3'h1, 8'h00, 4'h0, 4'h1, 16'h0017);
		dis = 8'h02;
		repeat (2) @(posedge ref_clk_i);
		#10;
		`CHK("selected", 4'h1, selected)
		go(3'h2, 8'h01, 4'h0, 4'h4, 16'h0002);
		go(3'h3, 8'h06, 4'h0, 4'h7, 16'h0020);
		val[3] = 16'h002d;
		go(3'h3, 8'h00, 4'h0, 4'h3, 16'h002d);
		val[3] = 16'h0002;
		go(3'h4, 8'hc3, 4'h0, 4'h0, 16'h0013);
		go(3'h4, 8'he3, 4'h0, 4'h5, 16'h0018);
		go(3'h5, 8'hf0, 4'h0, 4'h4, 16'h001a);
		`CHK("valid count", 4'h4, vcount)
		go(3'h5, 8'hef, 4'h0, 4'h1, 16'h0018);
		go(3'h4, 8'hef, 4'h0, 4'h5, 16'h0018);
		go(3'h2, 8'h04, 4'h3, 4'h3, 16'h002d);
		qual[2] = 2'h0;
		go(3'h2, 8'h00, 4'h3, 4'h0, 16'h002d);
		qual[2] = 2'h2;
		go(3'h2, 8'h00, 4'h9, 4'h0, 16'h0000);
		go(3'h1, 8'h00, 4'h0, 4'h1, 16'h0017);
		go(3'h7, 8'h00, 4'h0, 4'h0, 16'h0017);
		go(3'h0, 8'h00, 4'h0, 4'h0, 16'h0017);
		cfg.min_good = 4'h8;
		go(3'h1, 8'h01, 4'h0, 4'h0, 16'h0017);
		cfg.min_good = 4'h0;
		go(3'h1, 8'hff, 4'h0, 4'h0, 16'h0017);
		qual[0] = 2'h1;
		go(3'h1, 8'h00, 4'h0, 4'h2, 16'h0022);
		cfg.uncertain_as_good = 1'b1;
		go(3'h1, 8'h00, 4'h0, 4'h1, 16'h0017);
		qual[0] = 2'h2;
		cfg.block_mode_setting = 2'h1;
		go(3'h1, 8'h00, 4'h0, 4'h0, 16'h1234);
		man_value = 16'h4321;
		cfg.block_mode_setting = 2'h0;
		go(3'h1, 8'h00, 4'h0, 4'h0, 16'h1234);
		cfg.block_mode_setting = 2'h3;
		go(3'h1, 8'h00, 4'h0, 4'h0, 16'h1234);
		cfg.block_mode_setting = 2'h2;
		go(3'h6, 8'h00, 4'h0, 4'h1, 16'h0017);
		go(3'h6, 8'h01, 4'h0, 4'h2, 16'h0022);
		go(3'h6, 8'h00, 4'h0, 4'h2, 16'h0022);
		`CHK("latched", 4'h2, latched)
		// restore stands in for the saved choice across power loss
		restore = 4'h8;
		restore_load = 1'b1;
		@(posedge ref_clk_i);
		#10;
		restore_load = 1'b0;
		`CHK("latched", 4'h8, latched)
		go(3'h6, 8'h00, 4'h0, 4'h8, 16'h001b);
		go(3'h6, 8'h80, 4'h0, 4'h1, 16'h0017);
		`CHK("latched", 4'h1, latched)
		complete_run();
	end
endmodule
`default_nettype wire
